// file: core/ldm_dimming.v
/*
 * Dimming mode decision for an LED DC-DC controller: classifies the
 * dimming input into full-on, off, embedded PWM or an external digital
 * pattern, and gates the NMOS driver and the PMOS gate output together.
 * Registers are reached over AXI4-Lite. Threshold comparator flags, the
 * quantised level code and the fault flag arrive synchronous to aclk.
 */
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ldm_map.vh"

// Behaviour
// - Above high threshold: hold output fully on
// - Inside analog span: run embedded PWM engine
// - Below low threshold: hold output off
// - PWM gates NMOS driver and PMOS together
// - Digital pattern: full swing, under 1 kHz, no fault
// - Valid pattern high: drivers on, else off
// - Digital: pattern sets duty; analog: level, register
// - Analog level quantised into engine duty value
// - Engine alternates PMOS on and off
// - Duty resolved in 1024 steps
// - Duty scales linearly with input level
// - Fault stops engine, forces PMOS off
module ldm_dimming #(
   parameter CNT_W          = 20,
   parameter DUTY_W         = 10,
   parameter DIG_PERIOD_MIN = `LDM_DIG_PERIOD_MIN_US * `LDM_CLK_MHZ,
   parameter DIG_STALE      = `LDM_STALE_FACTOR * DIG_PERIOD_MIN
) (
   input  wire               aclk,
   input  wire               aresetn,
   input  wire [7:0]         s_axi_awaddr,
   input  wire               s_axi_awvalid,
   output reg                s_axi_awready,
   input  wire [31:0]        s_axi_wdata,
   input  wire [3:0]         s_axi_wstrb,
   input  wire               s_axi_wvalid,
   output reg                s_axi_wready,
   output reg  [1:0]         s_axi_bresp,
   output reg                s_axi_bvalid,
   input  wire               s_axi_bready,
   input  wire [7:0]         s_axi_araddr,
   input  wire               s_axi_arvalid,
   output reg                s_axi_arready,
   output reg  [31:0]        s_axi_rdata,
   output reg  [1:0]         s_axi_rresp,
   output reg                s_axi_rvalid,
   input  wire               s_axi_rready,
   input  wire               dim_above_high,
   input  wire               dim_below_low,
   input  wire               dim_in_span,
   input  wire [DUTY_W-1:0]  dim_level_input,
   input  wire               dim_freq_fault_pin,
   output reg                nmos_drv_en,
   output reg                pmos_gate_output
);

   localparam [CNT_W-1:0] PERIOD_MIN_C = DIG_PERIOD_MIN[CNT_W-1:0];
   localparam [CNT_W-1:0] STALE_C      = DIG_STALE[CNT_W-1:0];

   // ========================================================================
   // Helpers
   // ========================================================================
   function [31:0] merge_strb;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  strb;
      integer      i;
      begin
         merge_strb = old_val;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge_strb[i*8 +: 8] = new_val[i*8 +: 8];
            end
         end
      end
   endfunction

   // ========================================================================
   // Synchronous input flags
   // ========================================================================
   reg               above_reg;
   reg               below_reg;
   reg               span_reg;
   reg               fault_reg;
   reg  [DUTY_W-1:0] code_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         above_reg <= 1'b0;
         below_reg <= 1'b0;
         span_reg  <= 1'b0;
         fault_reg <= 1'b0;
         code_reg  <= {DUTY_W{1'b0}};
      end else begin
         above_reg <= dim_above_high;
         below_reg <= dim_below_low;
         span_reg  <= dim_in_span;
         fault_reg <= dim_freq_fault_pin;
         code_reg  <= dim_level_input;
      end
   end

   // ========================================================================
   // Digital pattern recognition
   // ========================================================================
   // A rising edge counts only after a visit below the low threshold, so an
   // analog level that drifts up never looks like a pattern. High pulses
   // shorter than the minimum on time are not filtered here.
   reg              last_low_reg;
   reg              seen_rise_reg;
   reg  [CNT_W-1:0] since_reg;
   reg              valid_reg;
   wire             rise;

   assign rise = above_reg & last_low_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         last_low_reg  <= 1'b0;
         seen_rise_reg <= 1'b0;
         since_reg     <= {CNT_W{1'b0}};
         valid_reg     <= 1'b0;
      end else begin
         if (below_reg) begin
            last_low_reg <= 1'b1;
         end else if (rise) begin
            last_low_reg <= 1'b0;
         end
         if (rise) begin
            since_reg     <= {CNT_W{1'b0}};
            seen_rise_reg <= 1'b1;
         end else if (since_reg != {CNT_W{1'b1}}) begin
            since_reg <= since_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         if (fault_reg) begin
            valid_reg <= 1'b0;
         end else if (rise) begin
            valid_reg <= seen_rise_reg & (since_reg >= PERIOD_MIN_C);
         end else if (since_reg >= STALE_C) begin
            valid_reg <= 1'b0;
         end
      end
   end

   // ========================================================================
   // Mode decision and output gating
   // ========================================================================
   reg  [1:0]       mode;
   reg              gate_next;
   reg  [CNT_W-1:0] period_tc_reg;
   wire             pwm_out;

   always @* begin
      mode = `LDM_MODE_OFF;
      if (fault_reg) begin
         mode = `LDM_MODE_OFF;
      end else if (valid_reg) begin
         mode = `LDM_MODE_DIG;
      end else if (above_reg) begin
         mode = `LDM_MODE_FULL;
      end else if (below_reg) begin
         mode = `LDM_MODE_OFF;
      end else if (span_reg) begin
         mode = `LDM_MODE_EMB;
      end
   end

   always @* begin
      case (mode)
         `LDM_MODE_FULL: gate_next = 1'b1;
         `LDM_MODE_EMB:  gate_next = pwm_out;
         `LDM_MODE_DIG:  gate_next = above_reg;
         default:        gate_next = 1'b0;
      endcase
   end

   ldm_pwm_engine #(
      .CNT_W  (CNT_W),
      .DUTY_W (DUTY_W)
   ) u_engine (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .enable    (mode == `LDM_MODE_EMB),
      .period_tc (period_tc_reg),
      .duty_code (code_reg),
      .pwm_out   (pwm_out)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         nmos_drv_en      <= 1'b0;
         pmos_gate_output <= 1'b0;
      end else begin
         nmos_drv_en      <= gate_next;
         pmos_gate_output <= gate_next;
      end
   end

   // ========================================================================
   // AXI4-Lite slave
   // ========================================================================
   reg  [7:0]  awaddr_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   wire        aw_held;
   wire        w_held;
   wire        do_write;
   reg  [31:0] cfg_word;
   reg  [31:0] rd_word;
   reg         rd_ok;
   wire [31:0] cfg_merged;

   // Held address/data means the ready dropped after a handshake
   assign aw_held  = ~s_axi_awready;
   assign w_held   = ~s_axi_wready;
   assign do_write = aw_held & w_held & ~s_axi_bvalid;
   assign cfg_merged = merge_strb(cfg_word, wdata_reg, wstrb_reg);

   always @* begin
      cfg_word = 32'h0;
      cfg_word[CNT_W-1:0] = period_tc_reg;
      rd_ok   = 1'b1;
      rd_word = 32'h0;
      case (s_axi_araddr)
         `LDM_ADDR_CONFIG: rd_word = cfg_word;
         `LDM_ADDR_STATUS: begin
            rd_word[`LDM_ST_MODE_LSB +: 2]           = mode;
            rd_word[`LDM_ST_VALID_BIT]               = valid_reg;
            rd_word[`LDM_ST_FAULT_BIT]               = fault_reg;
            rd_word[`LDM_ST_GATE_BIT]                = pmos_gate_output;
            rd_word[`LDM_ST_CODE_LSB +: DUTY_W]      = code_reg;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `LDM_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `LDM_RESP_OKAY;
         s_axi_rdata   <= 32'h0;
         awaddr_reg    <= 8'h0;
         wdata_reg     <= 32'h0;
         wstrb_reg     <= 4'h0;
         period_tc_reg <= `LDM_CONFIG_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_reg == `LDM_ADDR_CONFIG) begin
               period_tc_reg <= cfg_merged[CNT_W-1:0];
               s_axi_bresp   <= `LDM_RESP_OKAY;
            end else if (awaddr_reg == `LDM_ADDR_STATUS) begin
               s_axi_bresp <= `LDM_RESP_OKAY;
            end else begin
               s_axi_bresp <= `LDM_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? `LDM_RESP_OKAY : `LDM_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// file: core/ldm_map.vh
/*
 * Constants of the LED dimming mode and PWM block: register offsets,
 * field positions, reset values, mode codes and timing figures.
 * Assumes inclusion by bare name from the core design files.
 */
`ifndef LDM_MAP_VH
`define LDM_MAP_VH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define LDM_CLK_MHZ            40
`define LDM_DIG_PERIOD_MIN_US  1000
`define LDM_MIN_HIGH_NS        6000
`define LDM_STALE_FACTOR       4

// ==========================================================================
// Register map (byte addresses)
// ==========================================================================
`define LDM_ADDR_W             8
`define LDM_ADDR_CONFIG        8'h00
`define LDM_ADDR_STATUS        8'h04
`define LDM_CONFIG_RST         20'h1c4e5

// Status fields
`define LDM_ST_MODE_LSB        0
`define LDM_ST_VALID_BIT       2
`define LDM_ST_FAULT_BIT       3
`define LDM_ST_GATE_BIT        4
`define LDM_ST_CODE_LSB        8

// ==========================================================================
// Dimming modes
// ==========================================================================
`define LDM_MODE_OFF           2'h0
`define LDM_MODE_FULL          2'h1
`define LDM_MODE_EMB           2'h2
`define LDM_MODE_DIG           2'h3

// AXI responses
`define LDM_RESP_OKAY          2'h0
`define LDM_RESP_SLVERR        2'h2

`endif

// file: core/ldm_pwm_engine.v
/*
 * Embedded PWM engine: a period counter with a programmable terminal
 * count and a duty threshold scaled linearly from a quantised level code.
 * Assumes a synchronous active-low reset and a code that is already
 * registered by the caller.
 */
`timescale 1ns/1ps
`include "ldm_map.vh"

module ldm_pwm_engine #(
   parameter CNT_W  = 20,
   parameter DUTY_W = 10
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire              enable,
   input  wire [CNT_W-1:0]  period_tc,
   input  wire [DUTY_W-1:0] duty_code,
   output reg               pwm_out
);

   reg  [CNT_W-1:0]          cnt_reg;
   reg  [CNT_W:0]            thr_reg;
   wire [CNT_W+DUTY_W:0]     product;
   wire [CNT_W:0]            thr_next;
   wire [CNT_W:0]            tc_plus1;

   // Threshold is (tc+1)*code/1024, so duty follows the level linearly
   assign tc_plus1 = {1'b0, period_tc} + {{CNT_W{1'b0}}, 1'b1};
   assign product  = {{DUTY_W{1'b0}}, tc_plus1} * {{(CNT_W+1){1'b0}}, duty_code};
   assign thr_next = product[CNT_W+DUTY_W:DUTY_W];

   // ========================================================================
   // Period counter; duty is latched only at a period start so a moving
   // level never produces a runt pulse inside a period
   // ========================================================================
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= {CNT_W{1'b0}};
         thr_reg <= {(CNT_W+1){1'b0}};
         pwm_out <= 1'b0;
      end else if (!enable) begin
         cnt_reg <= {CNT_W{1'b0}};
         thr_reg <= thr_next;
         pwm_out <= 1'b0;
      end else begin
         if (cnt_reg >= period_tc) begin
            cnt_reg <= {CNT_W{1'b0}};
            thr_reg <= thr_next;
         end else begin
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         pwm_out <= ({1'b0, cnt_reg} < thr_reg);
      end
   end

endmodule

// file: testbench/ldm_dim_source.sv
/* Model of the dimming source: steady levels, a level in the span or a pattern.
   Assumes the bench picks the kind; mode 3 is the pattern. */
`timescale 1ns/1ps
module ldm_dim_source #(
   parameter MIN_HIGH = 4
) (
   input  wire        aclk,
   input  wire [1:0]  mode,
   input  wire [9:0]  code,
   input  wire [15:0] period,
   input  wire [15:0] high_len,
   output reg         dim_above_high = 1'h0,
   output reg         dim_below_low = 1'h1,
   output reg         dim_in_span = 1'h0,
   output reg  [9:0]  dim_level_input = 10'h000
);
   reg  [15:0] cnt = 16'h0000;
   wire        pat_hi = cnt < ((high_len < MIN_HIGH) ? MIN_HIGH : high_len);
   always @(posedge aclk) begin
      cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
      dim_above_high <= (mode == 2'h1) || (mode == 2'h3 && pat_hi);
      dim_below_low <= (mode == 2'h0) || (mode == 2'h3 && !pat_hi);
      dim_in_span <= (mode == 2'h2);
      // Outside the span the code means nothing, so it wanders
      dim_level_input <= (mode == 2'h2) ? code : ~dim_level_input;
   end
endmodule

// file: testbench/ldm_dimming_properties.sv
/* Port checker of the dimming block: output pairing, mode outcomes, AXI timing.
   Assumes a bind onto ldm_dimming and a synchronous active-low reset. */
`timescale 1ns/1ps
module ldm_dimming_properties (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        dim_above_high,
   input wire        dim_below_low,
   input wire        dim_in_span,
   input wire        dim_freq_fault_pin,
   input wire        nmos_drv_en,
   input wire        pmos_gate_output
);
   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Flags take two edges to reach the outputs, so look two cycles back
   sequence settled;
      $past(aresetn, 2) && $past(aresetn);
   endsequence
   AST_GATE_PAIR: assert property (pmos_gate_output == nmos_drv_en)
      else $error("gate outputs differ");
   AST_FULL_ON: assert property (settled ##0 ($past(dim_above_high, 2)
      && !$past(dim_freq_fault_pin, 2)) |-> pmos_gate_output) else $error("full level not on");
   AST_LOW_OFF: assert property (settled ##0 ($past(dim_below_low, 2)
      && !$past(dim_above_high, 2)) |-> !pmos_gate_output) else $error("low level not off");
   AST_FAULT_OFF: assert property (settled ##0 $past(dim_freq_fault_pin, 2)
      |-> !pmos_gate_output) else $error("fault left gate on");
   AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid) else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while busy");
   cover property ($rose(pmos_gate_output) && dim_in_span);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   cover property (dim_freq_fault_pin && dim_in_span);
endmodule

bind ldm_dimming ldm_dimming_properties ldm_dimming_properties_inst (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .dim_above_high, .dim_below_low, .dim_in_span,
   .dim_freq_fault_pin, .nmos_drv_en, .pmos_gate_output);

// file: testbench/tb.sv
/* Self-checking bench of the dimming block with a model of the source.
   Assumes ldm_map.vh on the include path. */
`timescale 1ns/1ps
`include "ldm_map.vh"
module tb;
   localparam TC = 99;
   reg         aclk = 1'h0;
   reg         aresetn = 1'h0;
   reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'h0;
   reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, dim_freq_fault_pin = 1'h0;
   reg  [1:0]  smode = 2'h1, r;
   reg  [9:0]  scode = 10'h000;
   reg  [15:0] sper = 16'h0050, shigh = 16'h001e;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        dim_above_high, dim_below_low, dim_in_span, nmos_drv_en, pmos_gate_output;
   wire [9:0]  dim_level_input;
   integer     n_fail = 0, tests_run = 0, seed = 32'h5944, i, k, hi;
   reg  [31:0] got;

   ldm_dimming #(.DIG_PERIOD_MIN(40), .DIG_STALE(160)) ldm_dimming_inst (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .dim_above_high, .dim_below_low, .dim_in_span,
      .dim_level_input, .dim_freq_fault_pin, .nmos_drv_en, .pmos_gate_output);
   ldm_dim_source ldm_dim_source_inst (.aclk, .mode(smode), .code(scode), .period(sper),
      .high_len(shigh), .dim_above_high, .dim_below_low, .dim_in_span, .dim_level_input);

   always #12.5 aclk = ~aclk;

   // ==========================================================
   // Checking and bus tasks
   // ==========================================================
   task chk(input [31:0] g, input [31:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // No cycle limit in the bus tasks: a hung slave is caught by the watchdog
   task axi_wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] resp);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         resp = 2'h3;
         while (resp === 2'h3) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
               resp = s_axi_bresp;
               s_axi_bready <= 1'h0;
            end
         end
         // Idle edge so a following call never reassigns bready in this step
         @(posedge aclk);
      end
   endtask
   task axi_rd(input [7:0] a, output [31:0] d, output [1:0] resp);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         resp = 2'h3;
         while (resp === 2'h3) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
               d = s_axi_rdata;
               resp = s_axi_rresp;
               s_axi_rready <= 1'h0;
            end
         end
         // Idle edge so a following call never reassigns rready in this step
         @(posedge aclk);
      end
   endtask
   task count_hi(input integer cyc, output integer h);
      begin
         h = 0;
         repeat (cyc) begin
            @(posedge aclk);
            if (pmos_gate_output === 1'h1) h = h + 1;
         end
      end
   endtask
   // High cycles of the engine over whole periods
   function integer exp_hi(input integer code, input integer periods);
      exp_hi = (((TC + 1) * code) >> 10) * periods;
   endfunction
   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, n_fail);
         if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask

   initial begin
      #(25 * 30000);
      n_fail = n_fail + 1;
      tally_and_finish;
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      axi_rd(`LDM_ADDR_CONFIG, got, r);
      chk(got, `LDM_CONFIG_RST);
      axi_wr(`LDM_ADDR_CONFIG, 32'hfff00000 | TC, 4'hf, r);
      axi_wr(`LDM_ADDR_CONFIG, 32'h0, 4'h0, r);
      axi_rd(`LDM_ADDR_CONFIG, got, r);
      chk(got, TC);
      axi_wr(8'h20, 32'h0, 4'hf, r);
      chk(r, `LDM_RESP_SLVERR);
      axi_rd(8'h20, got, r);
      chk(got, 32'h0);
      chk(r, `LDM_RESP_SLVERR);
      axi_wr(`LDM_ADDR_STATUS, 32'hffffffff, 4'hf, r);
      chk(r, `LDM_RESP_OKAY);
      $display("test registers done");
      for (i = 0; i < 2; i = i + 1) begin
         smode <= i[0] ? 2'h0 : 2'h1;
         repeat (10) @(posedge aclk);
         chk(pmos_gate_output, !i[0]);
         chk(nmos_drv_en, !i[0]);
         axi_rd(`LDM_ADDR_STATUS, got, r);
         chk(got[4:0], {!i[0], 2'h0, i[0] ? `LDM_MODE_OFF : `LDM_MODE_FULL});
      end
      $display("test steady levels done");
      smode <= 2'h2;
      for (i = 0; i < 6; i = i + 1) begin
         k = (i == 0) ? 0 : (i == 1) ? 1023 : ($random(seed) & 32'h3ff);
         scode <= k[9:0];
         repeat (300) @(posedge aclk);
         count_hi(400, hi);
         chk(hi, exp_hi(k, 4));
      end
      axi_rd(`LDM_ADDR_STATUS, got, r);
      chk({got[17:8], got[1:0]}, {k[9:0], `LDM_MODE_EMB});
      $display("test embedded engine done");
      scode <= 10'h3ff;
      repeat (300) @(posedge aclk);
      dim_freq_fault_pin <= 1'h1;
      repeat (4) @(posedge aclk);
      count_hi(200, hi);
      chk(hi, 0);
      axi_rd(`LDM_ADDR_STATUS, got, r);
      chk(got[4:3], 2'h1);
      dim_freq_fault_pin <= 1'h0;
      $display("test fault done");
      smode <= 2'h3;
      repeat (400) @(posedge aclk);
      count_hi(320, hi);
      chk(hi, 120);
      axi_rd(`LDM_ADDR_STATUS, got, r);
      chk(got[2:0], {1'h1, `LDM_MODE_DIG});
      dim_freq_fault_pin <= 1'h1;
      repeat (3) @(posedge aclk);
      // Read while the fault stands: once it clears the next rise may re-validate
      axi_rd(`LDM_ADDR_STATUS, got, r);
      chk(got[2], 1'h0);
      dim_freq_fault_pin <= 1'h0;
      sper <= 16'h0014;
      shigh <= 16'h0008;
      repeat (400) @(posedge aclk);
      axi_rd(`LDM_ADDR_STATUS, got, r);
      chk(got[2], 1'h0);
      $display("test digital pattern done");
      tally_and_finish;
   end
endmodule
